// >>> rtl/bwa_top.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Word copy puts second operand into first; flags unchanged.
// - After an interrupt-control write, interrupts wait until next instruction ends.
// - Word swap exchanges both 16-bit operands; flags unchanged.
// - Byte add stores the 8-bit sum in first operand, carry out to carry.
// - Add operations copy result bit 7 into the negative flag.
// - Add operations set zero flag exactly when the byte result is zero.
// - Add operations set half carry on carry from bit 3 into bit 4.
// - Add overflow flag is carry into bit 7 xor carry out of bit 7.
// - Add operations put the carry out of bit 7 into carry flag.
// - Add with carry also adds the carry flag at bit 0.
// - Byte subtract stores first minus second, borrow into carry flag.
// - Subtract operations: zero flag on zero difference, negative flag is bit 7.
// - Subtract operations set half carry on borrow from bit 4 into bit 3.
// - Subtract overflow flag is borrow into bit 7 xor borrow out of bit 7.
// - Subtract operations set carry flag on borrow out of bit 7.
// - Subtract with borrow also subtracts the carry flag at bit 0.
// - Byte AND stores the bitwise AND; negative is bit 7, zero on zero.
// - Logical operations: overflow flag is even parity; half carry, carry kept.
module bwa_top
  import bwa_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_INT_ALLOW,
  output logic O_BUSY,
  output logic [4:0] O_FLAGS
);
  bwa_alu_if alu_bus ();

  bwa_state_type state;
  bwa_op_type op;
  logic [15:0] first;
  logic [15:0] second;
  logic [4:0] flags;
  logic int_ctrl_write;
  logic lock;
  logic [15:0] count;

  logic access_start;
  logic access_done;
  logic wr_done;
  logic start_exec;
  logic wr_opa;
  logic wr_opb;
  logic wr_flags;
  logic commit;
  logic addr_known;
  logic op_legal;
  logic [31:0] next_rdata;
  logic next_err;

  function automatic logic legal_op(input logic [2:0] code);
    legal_op = (code != 3'b111);
  endfunction : legal_op

  // Write strobe of one register offset
  function automatic logic write_hit(input logic done, input logic [7:0] addr,
    input logic [7:0] ofs);
    write_hit = done && (addr == ofs);
  endfunction : write_hit

  bwa_alu u_alu (
    .alu(alu_bus.alu)
  );

  assign alu_bus.op = op;
  assign alu_bus.first = first;
  assign alu_bus.second = second;
  assign alu_bus.flags_in = flags;

  // APB handshake: one wait state, only taken while idle
  assign access_start = I_PSEL && I_PENABLE && !O_PREADY && (state == BWA_IDLE);
  assign access_done = I_PSEL && I_PENABLE && O_PREADY;
  assign wr_done = access_done && I_PWRITE && !O_PSLVERR;
  assign op_legal = legal_op(I_PWDATA[BWA_CMD_OP_LSB +: 3]);
  assign start_exec = write_hit(wr_done, I_PADDR, BWA_OFS_CMD);
  assign wr_opa = write_hit(wr_done, I_PADDR, BWA_OFS_OPA);
  assign wr_opb = write_hit(wr_done, I_PADDR, BWA_OFS_OPB);
  assign wr_flags = write_hit(wr_done, I_PADDR, BWA_OFS_FLAGS);
  assign commit = (state == BWA_EXEC);

  always_comb begin
    addr_known = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (I_PADDR)
      BWA_OFS_OPA: begin
        next_rdata = {16'h0000, first};
      end
      BWA_OFS_OPB: begin
        next_rdata = {16'h0000, second};
      end
      BWA_OFS_FLAGS: begin
        next_rdata = {27'h0000000, flags};
      end
      BWA_OFS_CMD: begin
        next_rdata[BWA_CMD_OP_LSB +: 3] = op;
        next_rdata[BWA_CMD_INTCTRL] = int_ctrl_write;
      end
      BWA_OFS_STATUS: begin
        next_rdata[BWA_STAT_BUSY] = (state == BWA_EXEC);
        next_rdata[BWA_STAT_LOCK] = lock;
      end
      BWA_OFS_COUNT: begin
        next_rdata = {16'h0000, count};
      end
      default: begin
        addr_known = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_err = !addr_known;
    if (I_PWRITE && (I_PADDR == BWA_OFS_CMD) && !op_legal) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= access_start;
      if (access_start) begin
        O_PSLVERR <= next_err;
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : next_rdata;
      end else begin
        O_PSLVERR <= 1'b0;
        O_PRDATA <= 32'h0000_0000;
      end
    end
  end

  // Instruction sequencing
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= BWA_IDLE;
    end else begin
      unique case (state)
        BWA_IDLE: begin
          if (start_exec) begin
            state <= BWA_EXEC;
          end
        end
        BWA_EXEC: begin
          state <= BWA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      op <= BWA_WORD_COPY_OP;
      int_ctrl_write <= 1'b0;
    end else if (start_exec) begin
      op <= bwa_op_type'(I_PWDATA[BWA_CMD_OP_LSB +: 3]);
      int_ctrl_write <= I_PWDATA[BWA_CMD_INTCTRL];
    end
  end

  // Operand registers: software loads, instruction commit overwrites
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      first <= BWA_RST_OPERAND;
      second <= BWA_RST_OPERAND;
    end else if (commit) begin
      first <= alu_bus.res_first;
      second <= alu_bus.res_second;
    end else if (wr_opa) begin
      first <= I_PWDATA[15:0];
    end else if (wr_opb) begin
      second <= I_PWDATA[15:0];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flags <= BWA_RST_FLAGS;
    end else if (commit) begin
      flags <= alu_bus.flags_out;
    end else if (wr_flags) begin
      flags <= I_PWDATA[4:0];
    end
  end

  // Interrupt lockout across the following instruction
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lock <= 1'b0;
    end else if (commit) begin
      lock <= int_ctrl_write;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_INT_ALLOW <= 1'b1;
    end else if (commit) begin
      O_INT_ALLOW <= !int_ctrl_write;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      count <= BWA_RST_COUNT;
    end else if (commit) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BUSY <= 1'b0;
    end else begin
      O_BUSY <= start_exec;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_FLAGS <= BWA_RST_FLAGS;
    end else if (commit) begin
      O_FLAGS <= alu_bus.flags_out;
    end else if (wr_flags) begin
      O_FLAGS <= I_PWDATA[4:0];
    end
  end
endmodule : bwa_top
`default_nettype wire

// >>> shared/bwa_pkg.sv
`default_nettype none
package bwa_pkg;
  // Register byte addresses
  localparam logic [7:0] BWA_OFS_OPA = 8'h00;
  localparam logic [7:0] BWA_OFS_OPB = 8'h04;
  localparam logic [7:0] BWA_OFS_FLAGS = 8'h08;
  localparam logic [7:0] BWA_OFS_CMD = 8'h0C;
  localparam logic [7:0] BWA_OFS_STATUS = 8'h10;
  localparam logic [7:0] BWA_OFS_COUNT = 8'h14;

  // Flag positions inside the flag register
  localparam int BWA_FLAG_CY = 0;
  localparam int BWA_FLAG_PV = 1;
  localparam int BWA_FLAG_AC = 2;
  localparam int BWA_FLAG_Z = 3;
  localparam int BWA_FLAG_S = 4;

  // Command register fields
  localparam int BWA_CMD_OP_LSB = 0;
  localparam int BWA_CMD_INTCTRL = 8;

  // Status register fields
  localparam int BWA_STAT_BUSY = 0;
  localparam int BWA_STAT_LOCK = 1;

  // Reset values
  localparam logic [15:0] BWA_RST_OPERAND = 16'h0000;
  localparam logic [4:0] BWA_RST_FLAGS = 5'h00;
  localparam logic [15:0] BWA_RST_COUNT = 16'h0000;

  typedef enum logic [2:0] {
    BWA_WORD_COPY_OP = 3'b000,
    BWA_WORD_SWAP_OP = 3'b001,
    BWA_SUM_OP = 3'b010,
    BWA_SUM_WITH_CARRY_OP = 3'b011,
    BWA_DIFFERENCE_OP = 3'b100,
    BWA_DIFFERENCE_WITH_BORROW_OP = 3'b101,
    BWA_AND_OP = 3'b110
  } bwa_op_type;

  typedef enum logic {
    BWA_IDLE = 1'b0,
    BWA_EXEC = 1'b1
  } bwa_state_type;
endpackage : bwa_pkg
`default_nettype wire

// >>> shared/bwa_alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bwa_alu_if;
  import bwa_pkg::*;
  bwa_op_type op;
  logic [15:0] first;
  logic [15:0] second;
  logic [4:0] flags_in;
  logic [15:0] res_first;
  logic [15:0] res_second;
  logic [4:0] flags_out;
  modport core (output op, output first, output second, output flags_in,
                input res_first, input res_second, input flags_out);
  modport alu (input op, input first, input second, input flags_in,
               output res_first, output res_second, output flags_out);
endinterface : bwa_alu_if
`default_nettype wire

// >>> rtl/bwa_alu.sv
`timescale 1ns/10ps
`default_nettype none
module bwa_alu
  import bwa_pkg::*;
(
  bwa_alu_if.alu alu
);
  logic [8:0] full;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [7:0] byte_res;
  logic carry_in;
  logic is_sub;

  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~(^v);
  endfunction : even_parity

  always_comb begin
    carry_in = 1'b0;
    if (alu.op == BWA_SUM_WITH_CARRY_OP || alu.op == BWA_DIFFERENCE_WITH_BORROW_OP) begin
      carry_in = alu.flags_in[BWA_FLAG_CY];
    end
    is_sub = (alu.op == BWA_DIFFERENCE_OP) || (alu.op == BWA_DIFFERENCE_WITH_BORROW_OP);
    if (is_sub) begin
      full = {1'b0, alu.first[7:0]} - {1'b0, alu.second[7:0]} - {8'h00, carry_in};
      nib = {1'b0, alu.first[3:0]} - {1'b0, alu.second[3:0]} - {4'h0, carry_in};
      low7 = {1'b0, alu.first[6:0]} - {1'b0, alu.second[6:0]} - {7'h00, carry_in};
    end else begin
      full = {1'b0, alu.first[7:0]} + {1'b0, alu.second[7:0]} + {8'h00, carry_in};
      nib = {1'b0, alu.first[3:0]} + {1'b0, alu.second[3:0]} + {4'h0, carry_in};
      low7 = {1'b0, alu.first[6:0]} + {1'b0, alu.second[6:0]} + {7'h00, carry_in};
    end
    byte_res = (alu.op == BWA_AND_OP) ? (alu.first[7:0] & alu.second[7:0]) : full[7:0];
    alu.res_first = {alu.first[15:8], byte_res};
    alu.res_second = alu.second;
    alu.flags_out = alu.flags_in;
    unique case (alu.op)
      BWA_WORD_COPY_OP: begin
        alu.res_first = alu.second;
      end
      BWA_WORD_SWAP_OP: begin
        alu.res_first = alu.second;
        alu.res_second = alu.first;
      end
      BWA_AND_OP: begin
        alu.flags_out[BWA_FLAG_S] = byte_res[7];
        alu.flags_out[BWA_FLAG_Z] = (byte_res == 8'h00);
        alu.flags_out[BWA_FLAG_PV] = even_parity(byte_res);
      end
      default: begin
        alu.flags_out[BWA_FLAG_S] = byte_res[7];
        alu.flags_out[BWA_FLAG_Z] = (byte_res == 8'h00);
        alu.flags_out[BWA_FLAG_AC] = nib[4];
        alu.flags_out[BWA_FLAG_PV] = low7[7] ^ full[8];
        alu.flags_out[BWA_FLAG_CY] = full[8];
      end
    endcase
  end
endmodule : bwa_alu
`default_nettype wire

// >>> tb/bwa_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module bwa_top_asserts (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_INT_ALLOW,
  input wire logic O_BUSY,
  input wire logic [4:0] O_FLAGS
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire wr_ok = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && !O_PSLVERR;
  wire cmd_wr = wr_ok && I_PADDR == 8'h0C;
  wire flags_wr = wr_ok && I_PADDR == 8'h08;
  a_copy_keeps_flags:
    assert property (cmd_wr && I_PWDATA[2:1] == 2'h0 |=> $stable(O_FLAGS) [*2])
    else $error("flags moved by copy or swap");
  a_lock_after_ctrl:
    assert property (cmd_wr && I_PWDATA[8] |-> ##2 !O_INT_ALLOW)
    else $error("interrupts not locked");
  a_allow_on_commit:
    assert property ($rose(O_INT_ALLOW) |-> $past(O_BUSY))
    else $error("interrupts unlocked outside commit");
  a_and_keeps_carry:
    assert property (cmd_wr && I_PWDATA[2:0] == 3'h6 |->
      ##2 ((O_FLAGS ^ $past(O_FLAGS, 2)) & 5'h05) == 5'h00)
    else $error("logical op changed carry flags");
  a_exec_after_cmd:
    assert property (cmd_wr |=> O_BUSY)
    else $error("no execute after command");
  a_busy_single:
    assert property (O_BUSY |=> !O_BUSY)
    else $error("execute longer than one cycle");
  a_flags_on_commit:
    assert property ($changed(O_FLAGS) |-> $past(O_BUSY) || $past(flags_wr) ||
      $past(flags_wr, 2))
    else $error("flags changed outside commit");
  a_answer_framed:
    assert property (O_PSLVERR || O_PRDATA != 32'h0 |-> O_PREADY && I_PSEL && I_PENABLE)
    else $error("answer outside access phase");
endmodule : bwa_top_asserts
`default_nettype wire

// >>> tb/bwa_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module bwa_top_tb_top;
  import bwa_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, allow, busy, e, busy_seen;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q;
  logic [4:0] flg;
  int num_errors = 0, samples_checked = 0;
  bwa_top dut_u (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .O_INT_ALLOW(allow), .O_BUSY(busy), .O_FLAGS(flg));
  always #20 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 8);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (prdy !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    @(posedge clk);
    busy_seen = busy;
  endtask : bus
  task automatic run(input logic [2:0] op, input logic [15:0] a, input logic [15:0] b,
    input logic [4:0] fi, input logic ic, input logic [15:0] ea, input logic [15:0] eb,
    input logic [4:0] ef);
    bus(1'b1, BWA_OFS_OPA, {16'h0, a});
    bus(1'b1, BWA_OFS_OPB, {16'h0, b});
    bus(1'b1, BWA_OFS_FLAGS, {27'h0, fi});
    bus(1'b1, BWA_OFS_CMD, {23'h0, ic, 5'h0, op});
    chk({31'h0, busy_seen}, 32'h1);
    bus(1'b0, BWA_OFS_STATUS, 32'h0);
    chk(q, {30'h0, ic, 1'b0});
    bus(1'b0, BWA_OFS_CMD, 32'h0);
    chk(q, {23'h0, ic, 5'h0, op});
    bus(1'b0, BWA_OFS_OPA, 32'h0);
    chk(q, {16'h0, ea});
    chk({31'h0, busy_seen}, 32'h0);
    bus(1'b0, BWA_OFS_OPB, 32'h0);
    chk(q, {16'h0, eb});
    chk({27'h0, flg}, {27'h0, ef});
    chk({31'h0, allow}, {31'h0, !ic});
    $display("test op %0d done", op);
  endtask : run
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, allow}, 32'h1);
    bus(1'b0, BWA_OFS_FLAGS, 32'h0);
    chk(q, 32'h0);
    run(3'h0, 16'h1234, 16'hABCD, 5'h1F, 1'b0, 16'hABCD, 16'hABCD, 5'h1F);
    run(3'h1, 16'h1234, 16'hABCD, 5'h0A, 1'b1, 16'hABCD, 16'h1234, 5'h0A);
    run(3'h2, 16'h5A7F, 16'h0001, 5'h00, 1'b1, 16'h5A80, 16'h0001, 5'h16);
    run(3'h2, 16'h00FF, 16'h0001, 5'h00, 1'b0, 16'h0000, 16'h0001, 5'h0D);
    run(3'h3, 16'h0010, 16'h00F0, 5'h01, 1'b0, 16'h0001, 16'h00F0, 5'h01);
    run(3'h3, 16'h0080, 16'h0080, 5'h00, 1'b0, 16'h0000, 16'h0080, 5'h0B);
    run(3'h4, 16'h0080, 16'h0001, 5'h00, 1'b0, 16'h007F, 16'h0001, 5'h06);
    run(3'h4, 16'h3305, 16'h0005, 5'h1F, 1'b0, 16'h3300, 16'h0005, 5'h08);
    run(3'h5, 16'h0000, 16'h0000, 5'h01, 1'b0, 16'h00FF, 16'h0000, 5'h15);
    run(3'h5, 16'h0050, 16'h0030, 5'h00, 1'b0, 16'h0020, 16'h0030, 5'h00);
    run(3'h6, 16'hFFF0, 16'h003C, 5'h05, 1'b0, 16'hFF30, 16'h003C, 5'h07);
    run(3'h6, 16'h0000, 16'h00FF, 5'h1A, 1'b0, 16'h0000, 16'h00FF, 5'h0A);
    bus(1'b1, BWA_OFS_CMD, 32'h7);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, busy_seen}, 32'h0);
    bus(1'b0, 8'h3C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    bus(1'b1, BWA_OFS_COUNT, 32'hFFFF);
    chk({31'h0, e}, 32'h0);
    bus(1'b0, BWA_OFS_COUNT, 32'h0);
    chk(q, 32'h0000000C);
    $display("test bus errors done");
    bus(1'b1, BWA_OFS_CMD, 32'h100);
    bus(1'b0, BWA_OFS_STATUS, 32'h0);
    chk(q, 32'h2);
    chk({31'h0, allow}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, allow}, 32'h1);
    bus(1'b0, BWA_OFS_COUNT, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : bwa_top_tb_top
bind bwa_top bwa_top_asserts chk_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_INT_ALLOW(O_INT_ALLOW), .O_BUSY(O_BUSY), .O_FLAGS(O_FLAGS));
`default_nettype wire
